// ===== core/gpio_cde_pkg.sv
// package: register map, field positions and pin carriers for ports c, d, e
package gpio_cde_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_PORT_C_DATA = 8'h02;
  localparam logic [7:0] OFS_PORT_D_DATA = 8'h03;
  localparam logic [7:0] OFS_PORT_C_DIR  = 8'h06;
  localparam logic [7:0] OFS_PORT_D_DIR  = 8'h07;
  localparam logic [7:0] OFS_PORT_E_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT_E_DIR  = 8'h0C;

  // field positions
  localparam int unsigned SYSCLK_EN_BIT  = 7;
  localparam int unsigned SYSCLK_PIN     = 2;
  localparam int unsigned PORT_C_WIDTH   = 6;
  localparam int unsigned TA_CLK_PIN     = 6;
  localparam int unsigned TB_CLK_PIN     = 4;
  localparam int unsigned SPI_SCK_PIN    = 7;
  localparam int unsigned SPI_MOSI_PIN   = 6;
  localparam int unsigned SPI_MISO_PIN   = 5;
  localparam int unsigned SPI_SS_PIN     = 4;
  localparam int unsigned TA_CH1_PIN     = 3;
  localparam int unsigned TA_CH0_PIN     = 2;
  localparam int unsigned SCI_RX_PIN     = 1;
  localparam int unsigned SCI_TX_PIN     = 0;

  // reset values
  localparam logic [7:0] DIR_RESET       = 8'h00;
  localparam logic [7:0] LATCH_RESET     = 8'h00;
  localparam logic [7:0] RDATA_RESET     = 8'h00;
  localparam logic [7:0] PORT_C_MASK     = 8'h3F;

  // peripheral control levels seen by the port
  typedef struct packed {
    logic       spi_enable_bit;
    logic       spi_master_select;
    logic       mode_fault_enable;
    logic       serial_if_enable;
    logic [1:0] edge_level_select_ch1;
    logic [1:0] edge_level_select_ch0;
    logic       timer_a_ext_sel;
    logic       timer_b_ext_sel;
    logic [6:0] adc_pin_sel;
  } periph_ctrl_t;

  // peripheral drive toward port e pins
  typedef struct packed {
    logic sck_out;
    logic mosi_out;
    logic miso_out;
    logic ch1_out;
    logic ch1_oe;
    logic ch0_out;
    logic ch0_oe;
    logic tx_out;
  } periph_drive_t;

  // two-signal pin group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

endpackage : gpio_cde_pkg

// ===== core/gpio_cde_ports.sv
// file: ports c, d and e with peripheral pin sharing and register slave
//
// Notes on behaviour
// - clock enable bit drives sysclk onto c2
// - with clock out, c2 drive ignores direction bit; with it set, c2 reads zero
// - clock enable bit readable, writable, reset clear
// - direction one drives pin, zero inputs
// - reset clears all three direction registers
// - data read gives latch or pin per direction
// - latch writes always land, input pin unaffected
// - adc pin reads zero when input
// - timer owns d pin, reads latch or zero
// - d6, d4 become timer clock inputs
// - e7 is spi clock, direction from mode
// - e6, e5 carry mosi and miso
// - e4 slave select unless disabled or master-nofault
// - slave mode ignores e4 direction bit
// - e3, e2 follow timer channel select
// - e1, e0 carry sci receive, transmit
// - peripheral e pins ignore direction, reads unchanged
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module gpio_cde_ports
  import gpio_cde_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                arst_n_in,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [DATA_W-1:0]   wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [DATA_W-1:0]   rdata_out,
  input  wire logic                sysclk_in,
  input  wire periph_ctrl_t        ctrl_in,
  input  wire periph_drive_t       drive_in,
  input  wire logic [7:0]          pin_c_in,
  input  wire logic [7:0]          pin_d_in,
  input  wire logic [7:0]          pin_e_in,
  output pin_drive_t               pin_c_out,
  output pin_drive_t               pin_d_out,
  output pin_drive_t               pin_e_out,
  output logic                     timer_a_ext_clock_out,
  output logic                     timer_b_ext_clock_out,
  output logic                     spi_serial_clock_out,
  output logic                     spi_mosi_out,
  output logic                     spi_miso_out,
  output logic                     spi_ss_n_out,
  output logic                     timer_a_channel_pin_out,
  output logic                     serial_rx_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] port_c_latch;
  logic [7:0] port_d_latch;
  logic [7:0] port_e_latch;
  logic [7:0] dir_reg_c;
  logic [7:0] dir_reg_d;
  logic [7:0] dir_reg_e;
  logic       sysclk_out_enable;
  logic [7:0] sync1_c_reg, sync2_c_reg;
  logic [7:0] sync1_d_reg, sync2_d_reg;
  logic [7:0] sync1_e_reg, sync2_e_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pin);
    read_mix = (dir & lat) | (~dir & pin);
  endfunction : read_mix

  function automatic logic ch_used(input logic [1:0] els);
    ch_used = |els;
  endfunction : ch_used

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_c_reg <= 8'h00;
      sync2_c_reg <= 8'h00;
      sync1_d_reg <= 8'h00;
      sync2_d_reg <= 8'h00;
      sync1_e_reg <= 8'h00;
      sync2_e_reg <= 8'h00;
    end else begin
      sync1_c_reg <= pin_c_in;
      sync2_c_reg <= sync1_c_reg;
      sync1_d_reg <= pin_d_in;
      sync2_d_reg <= sync1_d_reg;
      sync1_e_reg <= pin_e_in;
      sync2_e_reg <= sync1_e_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data latches: reset leaves them at a fixed value
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port_c_latch <= LATCH_RESET;
      port_d_latch <= LATCH_RESET;
      port_e_latch <= LATCH_RESET;
    end else if (wr_in) begin
      if (addr_in == OFS_PORT_C_DATA) begin
        port_c_latch <= wdata_in & PORT_C_MASK;
      end
      if (addr_in == OFS_PORT_D_DATA) begin
        port_d_latch <= wdata_in;
      end
      if (addr_in == OFS_PORT_E_DATA) begin
        port_e_latch <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction registers and clock enable
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_reg_c         <= DIR_RESET;
      dir_reg_d         <= DIR_RESET;
      dir_reg_e         <= DIR_RESET;
      sysclk_out_enable <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == OFS_PORT_C_DIR) begin
        dir_reg_c         <= wdata_in & PORT_C_MASK;
        sysclk_out_enable <= wdata_in[SYSCLK_EN_BIT];
      end
      if (addr_in == OFS_PORT_D_DIR) begin
        dir_reg_d <= wdata_in;
      end
      if (addr_in == OFS_PORT_E_DIR) begin
        dir_reg_e <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ownership of pins
  logic       ss_used;
  logic [7:0] d_owned;
  logic [7:0] e_owned;
  logic [7:0] e_per_oe;
  logic [7:0] e_per_out;

  always_comb begin
    ss_used = ctrl_in.spi_enable_bit &&
              !(ctrl_in.spi_master_select && !ctrl_in.mode_fault_enable);
    d_owned = 8'h00;
    d_owned[TA_CLK_PIN] = ctrl_in.timer_a_ext_sel;
    d_owned[TB_CLK_PIN] = ctrl_in.timer_b_ext_sel;
    e_owned = 8'h00;
    e_owned[SPI_SCK_PIN]  = ctrl_in.spi_enable_bit;
    e_owned[SPI_MOSI_PIN] = ctrl_in.spi_enable_bit;
    e_owned[SPI_MISO_PIN] = ctrl_in.spi_enable_bit;
    e_owned[SPI_SS_PIN]   = ss_used;
    e_owned[TA_CH1_PIN]   = ch_used(ctrl_in.edge_level_select_ch1);
    e_owned[TA_CH0_PIN]   = ch_used(ctrl_in.edge_level_select_ch0);
    e_owned[SCI_RX_PIN]   = ctrl_in.serial_if_enable;
    e_owned[SCI_TX_PIN]   = ctrl_in.serial_if_enable;
    e_per_oe  = 8'h00;
    e_per_out = 8'h00;
    e_per_oe[SPI_SCK_PIN]   = ctrl_in.spi_master_select;
    e_per_out[SPI_SCK_PIN]  = drive_in.sck_out;
    e_per_oe[SPI_MOSI_PIN]  = ctrl_in.spi_master_select;
    e_per_out[SPI_MOSI_PIN] = drive_in.mosi_out;
    e_per_oe[SPI_MISO_PIN]  = !ctrl_in.spi_master_select;
    e_per_out[SPI_MISO_PIN] = drive_in.miso_out;
    e_per_oe[TA_CH1_PIN]    = drive_in.ch1_oe;
    e_per_out[TA_CH1_PIN]   = drive_in.ch1_out;
    e_per_oe[TA_CH0_PIN]    = drive_in.ch0_oe;
    e_per_out[TA_CH0_PIN]   = drive_in.ch0_out;
    e_per_oe[SCI_TX_PIN]    = 1'b1;
    e_per_out[SCI_TX_PIN]   = drive_in.tx_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_comb begin
    pin_c_out.oe  = dir_reg_c & PORT_C_MASK;
    pin_c_out.out = port_c_latch;
    if (sysclk_out_enable) begin
      pin_c_out.oe[SYSCLK_PIN]  = 1'b1;
      pin_c_out.out[SYSCLK_PIN] = sysclk_in;
    end
    pin_d_out.oe  = dir_reg_d & ~d_owned;
    pin_d_out.out = port_d_latch;
    pin_e_out.oe  = (dir_reg_e & ~e_owned) | (e_per_oe & e_owned);
    pin_e_out.out = (port_e_latch & ~e_owned) | (e_per_out & e_owned);
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral inputs from synchronised pins
  assign timer_a_ext_clock_out   = ctrl_in.timer_a_ext_sel & sync2_d_reg[TA_CLK_PIN];
  assign timer_b_ext_clock_out   = ctrl_in.timer_b_ext_sel & sync2_d_reg[TB_CLK_PIN];
  assign spi_serial_clock_out    = ctrl_in.spi_enable_bit & sync2_e_reg[SPI_SCK_PIN];
  assign spi_mosi_out            = ctrl_in.spi_enable_bit & sync2_e_reg[SPI_MOSI_PIN];
  assign spi_miso_out            = ctrl_in.spi_enable_bit & sync2_e_reg[SPI_MISO_PIN];
  assign spi_ss_n_out            = !ss_used | sync2_e_reg[SPI_SS_PIN];
  assign timer_a_channel_pin_out = e_owned[TA_CH0_PIN] & sync2_e_reg[TA_CH0_PIN];
  assign serial_rx_out           = !ctrl_in.serial_if_enable | sync2_e_reg[SCI_RX_PIN];

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [7:0] d_read;
  logic [7:0] d_zero;
  logic [7:0] c_read;

  always_comb begin
    c_read = read_mix(dir_reg_c, port_c_latch, sync2_c_reg) & PORT_C_MASK;
    if (sysclk_out_enable && dir_reg_c[SYSCLK_PIN]) begin
      c_read[SYSCLK_PIN] = 1'b0;
    end
    d_zero = d_owned | {1'b0, ctrl_in.adc_pin_sel};
    d_read = (read_mix(dir_reg_d, port_d_latch, sync2_d_reg) & ~d_zero)
           | (dir_reg_d & port_d_latch & d_zero);
    rdata_next = rdata_reg;
    if (rd_in) begin
      case (addr_in)
        OFS_PORT_C_DATA: rdata_next = c_read;
        OFS_PORT_D_DATA: rdata_next = d_read;
        OFS_PORT_E_DATA: rdata_next = read_mix(dir_reg_e, port_e_latch, sync2_e_reg);
        OFS_PORT_C_DIR:  rdata_next = {sysclk_out_enable, 1'b0, dir_reg_c[5:0]};
        OFS_PORT_D_DIR:  rdata_next = dir_reg_d;
        OFS_PORT_E_DIR:  rdata_next = dir_reg_e;
        default:         rdata_next = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

endmodule : gpio_cde_ports

// ===== tb/gpio_cde_sva.sv
// checker: bus timing and pin ownership properties of the port block
`timescale 1ns/10ps
module gpio_cde_sva
  import gpio_cde_pkg::*;
(
  input wire logic              mclk_in,
  input wire logic              arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire periph_ctrl_t      ctrl_in,
  input wire pin_drive_t        pin_c_out,
  input wire pin_drive_t        pin_d_out,
  input wire pin_drive_t        pin_e_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////
  rdata_hold_a: assert property (!rd_in |=> $stable(rdata_out))
    else $error("read data moved without a read");
  sysclk_oe_a: assert property (wr_in && addr_in == OFS_PORT_C_DIR && wdata_in[7] |=> pin_c_out.oe[2])
    else $error("c2 not driven with clock out on");
  dir_c_a: assert property (wr_in && addr_in == OFS_PORT_C_DIR && !wdata_in[7]
    |=> pin_c_out.oe == ($past(wdata_in) & 8'h3F)) else $error("c enables differ from direction");
  dir_d_a: assert property (wr_in && addr_in == OFS_PORT_D_DIR && !ctrl_in.timer_a_ext_sel
    && !ctrl_in.timer_b_ext_sel |=> pin_d_out.oe == $past(wdata_in)) else $error("d enables differ");
  reset_dir_a: assert property ($rose(arst_n_in) |-> pin_c_out.oe == 8'h00 && pin_d_out.oe == 8'h00)
    else $error("pins driven after reset");
  timer_pin_a: assert property (ctrl_in.timer_a_ext_sel |-> !pin_d_out.oe[6])
    else $error("d6 driven while timer clock");
  spi_master_a: assert property (ctrl_in.spi_enable_bit && ctrl_in.spi_master_select
    |-> pin_e_out.oe[7:6] == 2'b11 && !pin_e_out.oe[5]) else $error("master spi pin enables wrong");
  spi_slave_a: assert property (ctrl_in.spi_enable_bit && !ctrl_in.spi_master_select
    |-> pin_e_out.oe[7:4] == 4'h2) else $error("slave spi pin enables wrong");
  sci_pins_a: assert property (ctrl_in.serial_if_enable |-> pin_e_out.oe[1:0] == 2'b01)
    else $error("sci pin enables wrong");
endmodule : gpio_cde_sva
bind gpio_cde_ports gpio_cde_sva gpio_cde_sva_inst (.mclk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .ctrl_in, .pin_c_out, .pin_d_out, .pin_e_out);

// ===== tb/gpio_cde_pins_model.sv
// partner model: pin levels seen from outside the port block
`timescale 1ns/10ps
module gpio_cde_pins_model
  import gpio_cde_pkg::*;
(
  input  wire pin_drive_t drv_c_in,
  input  wire pin_drive_t drv_d_in,
  input  wire pin_drive_t drv_e_in,
  input  wire logic [7:0] ext_c_in,
  input  wire logic [7:0] ext_d_in,
  input  wire logic [7:0] ext_e_in,
  output logic      [7:0] lvl_c_out,
  output logic      [7:0] lvl_d_out,
  output logic      [7:0] lvl_e_out
);
  // driven bits follow the port, released bits the outside source
  assign lvl_c_out = (drv_c_in.oe & drv_c_in.out) | (~drv_c_in.oe & ext_c_in);
  assign lvl_d_out = (drv_d_in.oe & drv_d_in.out) | (~drv_d_in.oe & ext_d_in);
  assign lvl_e_out = (drv_e_in.oe & drv_e_in.out) | (~drv_e_in.oe & ext_e_in);
endmodule : gpio_cde_pins_model

// ===== tb/shared_gpio_ports_c_d_e_tb.sv
// testbench: register access, pin mixing and peripheral pin sharing
`timescale 1ns/10ps
module shared_gpio_ports_c_d_e_tb
  import gpio_cde_pkg::*;
;
  logic          mclk_in = 1'b0, arst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, sysclk_in = 1'b0;
  logic [7:0]    addr_in = 8'h00, wdata_in = 8'h00, ext_c = 8'h00, ext_d = 8'h00, ext_e = 8'h00;
  logic [7:0]    rdata_out, lc, ld, le;
  logic          ta_clk, tb_clk, sck, mosi, miso, tch, ss_n, rx;
  periph_ctrl_t  ctrl_in = '0;
  periph_drive_t drive_in = 8'hA6;
  pin_drive_t    pc, pd, pe;
  int            err_count = 0, checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////
  gpio_cde_ports gpio_cde_ports_inst (.mclk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .sysclk_in, .ctrl_in, .drive_in, .pin_c_in(lc), .pin_d_in(ld), .pin_e_in(le), .pin_c_out(pc),
    .pin_d_out(pd), .pin_e_out(pe), .timer_a_ext_clock_out(ta_clk), .timer_b_ext_clock_out(tb_clk),
    .spi_serial_clock_out(sck), .spi_mosi_out(mosi), .spi_miso_out(miso), .spi_ss_n_out(ss_n),
    .timer_a_channel_pin_out(tch), .serial_rx_out(rx));
  gpio_cde_pins_model gpio_cde_pins_model_inst (.drv_c_in(pc), .drv_d_in(pd), .drv_e_in(pe),
    .ext_c_in(ext_c), .ext_d_in(ext_d), .ext_e_in(ext_e), .lvl_c_out(lc), .lvl_d_out(ld), .lvl_e_out(le));
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    sysclk_in <= ~sysclk_in;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task rc(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(n, e, rdata_out);
  endtask : rc
  task wait3;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask : wait3
  ////////////////////////////////////////////////////////////
  task s_reset;
    rc("c_dir", OFS_PORT_C_DIR, 8'h00);
    rc("d_dir", OFS_PORT_D_DIR, 8'h00);
    rc("e_dir", OFS_PORT_E_DIR, 8'h00);
    chk("e_oe", 8'h00, pe.oe);
    wr(8'h05, 8'hFF);
    rc("hole", 8'h05, 8'h00);
  endtask : s_reset
  task s_port_c;
    ext_c <= 8'h2A;
    wr(OFS_PORT_C_DATA, 8'h15);
    rc("c_pin", OFS_PORT_C_DATA, 8'h2A);
    wr(OFS_PORT_C_DIR, 8'h3F);
    rc("c_latch", OFS_PORT_C_DATA, 8'h15);
    chk("c_oe", 8'h3F, pc.oe);
    chk("c_out", 8'h15, pc.out & 8'h3F);
    wr(OFS_PORT_C_DIR, 8'hC0);
    rc("c_en", OFS_PORT_C_DIR, 8'h80);
    chk("c_oe2", 8'h04, pc.oe);
    chk("c_clk", {7'h00, sysclk_in}, {7'h00, pc.out[2]});
    wr(OFS_PORT_C_DIR, 8'hBF);
    rc("c_mix", OFS_PORT_C_DATA, 8'h11);
    wr(OFS_PORT_C_DIR, 8'h00);
  endtask : s_port_c
  task s_port_d;
    ext_d <= 8'hFC;
    wr(OFS_PORT_D_DATA, 8'hE5);
    wr(OFS_PORT_D_DIR, 8'h0F);
    rc("d_mix", OFS_PORT_D_DATA, 8'hF5);
    ctrl_in <= 17'h0_0031;
    rc("d_adc", OFS_PORT_D_DATA, 8'hC5);
    chk("d_adc_oe", 8'h0F, pd.oe);
    ctrl_in <= 17'h0_0180;
    rc("d_tim", OFS_PORT_D_DATA, 8'hA5);
    chk("d_tclk", 8'h03, {6'h00, ta_clk, tb_clk});
    wr(OFS_PORT_D_DIR, 8'hFF);
    rc("d_tim_rd", OFS_PORT_D_DATA, 8'hE5);
    chk("d_tim_oe", 8'hAF, pd.oe);
    ctrl_in <= '0;
    wait3;
    chk("d_gp_oe", 8'hFF, pd.oe);
    chk("d_tclk_off", 8'h00, {6'h00, ta_clk, tb_clk});
  endtask : s_port_d
  task s_port_e;
    ext_e <= 8'h5A;
    ctrl_in <= 17'h1_E200;
    wr(OFS_PORT_E_DATA, 8'h3C);
    wr(OFS_PORT_E_DIR, 8'h0F);
    rc("e_mix", OFS_PORT_E_DATA, 8'h9C);
    chk("e_oe_m", 8'hCD, pe.oe);
    chk("e_out_m", 8'h8C, pe.out & pe.oe);
    chk("e_rx", 8'h01, {7'h00, rx});
    chk("e_in_m", 8'h01, {6'h00, miso, tch});
    ext_e <= 8'h4A;
    ctrl_in <= 17'h1_6200;
    wr(OFS_PORT_E_DIR, 8'hFF);
    wait3;
    chk("e_oe_s", 8'h2D, pe.oe);
    chk("e_spi_s", 8'h02, {5'h00, sck, mosi, ss_n});
    chk("e_in_s", 8'h03, {6'h00, miso, tch});
    rc("e_latch", OFS_PORT_E_DATA, 8'h3C);
    ctrl_in <= 17'h1_8000;
    wait3;
    chk("e_oe_g", 8'hDF, pe.oe);
    ctrl_in <= '0;
    wait3;
    chk("e_oe_off", 8'hFF, pe.oe);
    chk("e_off", 8'h03, {4'h0, sck, mosi, ss_n, rx});
    chk("e_in_off", 8'h00, {6'h00, miso, tch});
  endtask : s_port_e
  initial begin
    repeat (5) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    s_reset();
    s_port_c();
    s_port_d();
    s_port_e();
    print_verdict();
  end
endmodule : shared_gpio_ports_c_d_e_tb
